//--- verilog/rsx_consts.svh
/*
  constants of the rotate / subtract / sleep execution block: widths,
  register addresses, control bit positions and reset values.
  assumes it is included by bare name from the package and the modules.
*/
`ifndef RSX_CONSTS_SVH
`define RSX_CONSTS_SVH

`define DATA_W 8
`define FADDR_W 7
`define BUS_AW 8
`define NIB_W 4
`define STATUS_W 5
`define OP_W 3

`define ADDR_ACC 8'h80
`define ADDR_STATUS 8'h81
`define ADDR_CTRL 8'h82

`define CTRL_SLEEP_POS 0
`define CTRL_WAKE_POS 1
`define CTRL_ILLEGAL_POS 2

`define DEST_FILE 1'b1
`define ACC_RST 8'h00
`define STATUS_RST 5'h18
`define ZERO_BYTE 8'h00

`endif

//--- verilog/rsx_pkg.sv
/*
  types of the rotate / subtract / sleep execution block.
  assumes rsx_consts.svh is on the include path.
*/
`include "rsx_consts.svh"

package rsx_pkg;

  typedef enum logic [`OP_W-1:0] {
    op_none = 3'h0,
    rotate_left_op = 3'h1,
    rotate_right_op = 3'h2,
    sub_from_literal_op = 3'h3,
    sub_acc_from_file_op = 3'h4,
    sleep_op = 3'h5
  } op_t;

  // gray along idle-exec-idle and idle-sleep-idle
  typedef enum logic [1:0] {
    st_idle = 2'h0,
    st_exec = 2'h1,
    st_sleep = 2'h2
  } fsm_t;

  typedef struct packed {
    op_t op;
    logic [`FADDR_W-1:0] faddr;
    logic dest;
    logic [`DATA_W-1:0] lit;
  } inst_t;

  typedef struct packed {
    logic timeout_bit;
    logic powerdown_bit;
    logic zero_bit;
    logic nibble_borrow_bit;
    logic carry_bit;
  } status_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [`BUS_AW-1:0] addr;
    logic [`DATA_W-1:0] wdata;
  } bus_req_t;

  typedef struct packed {
    fsm_t fsm;
    inst_t inst;
    logic [`DATA_W-1:0] acc;
    status_t st;
    logic ready;
    logic osc_stop;
    logic wdt_clr;
    logic illegal;
  } exec_state_t;

  typedef struct packed {
    logic [`DATA_W-1:0] a_data;
    logic [`DATA_W-1:0] b_data;
  } mem_state_t;

endpackage

//--- verilog/file_mem.sv
/*
  128 x 8 data file with one write port and two registered read ports;
  port a can return a bypass word instead of the array word.
  assumes one clock, synchronous active-high reset of the read registers.
*/
`timescale 1ns/1ns
`include "rsx_consts.svh"

module file_mem (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic we_in,
  input wire logic [`FADDR_W-1:0] waddr_in,
  input wire logic [`DATA_W-1:0] wdata_in,
  input wire logic [`FADDR_W-1:0] a_addr_in,
  input wire logic a_byp_in,
  input wire logic [`DATA_W-1:0] a_byp_data_in,
  input wire logic b_en_in,
  input wire logic [`FADDR_W-1:0] b_addr_in,
  output logic [`DATA_W-1:0] a_data_out,
  output logic [`DATA_W-1:0] b_data_out
);

  // array not reset: contents undefined until written
  logic [`DATA_W-1:0] mem [0:(1<<`FADDR_W)-1];
  rsx_pkg::mem_state_t q;
  rsx_pkg::mem_state_t d;

  always_comb begin
    d = q;
    d.a_data = a_byp_in ? a_byp_data_in : mem[a_addr_in];
    // read during write returns the old word
    if (b_en_in) begin
      d.b_data = mem[b_addr_in];
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
  end

  assign a_data_out = q.a_data;
  assign b_data_out = q.b_data;

endmodule

//--- verilog/rotate_subtract_sleep_exec.sv
/*
  execution datapath for rotate-through-carry, subtract and sleep
  instructions, with its own data file, accumulator and status flags.
  assumes a decoder that offers one instruction at a time with valid and
  ready, a wake source on the same clock, and a plain register port.
*/
`timescale 1ns/1ns
`include "rsx_consts.svh"

module rotate_subtract_sleep_exec (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire rsx_pkg::bus_req_t bus_in,
  output logic [`DATA_W-1:0] rd_data_out,
  input wire logic inst_valid_in,
  input wire rsx_pkg::inst_t inst_in,
  output logic inst_ready_out,
  input wire logic wake_in,
  output logic osc_stop_out,
  output logic wdt_clear_out,
  output logic [`DATA_W-1:0] acc_out,
  output rsx_pkg::status_t status_out
);

  ////////////////////////////////////////////////////////////////////
  // state and reset value

  localparam rsx_pkg::exec_state_t RST_STATE = '{
    fsm: rsx_pkg::st_idle,
    inst: '0,
    acc: `ACC_RST,
    st: rsx_pkg::status_t'(`STATUS_RST),
    ready: 1'b1,
    osc_stop: 1'b0,
    wdt_clr: 1'b0,
    illegal: 1'b0
  };

  rsx_pkg::exec_state_t q;
  rsx_pkg::exec_state_t d;

  ////////////////////////////////////////////////////////////////////
  // datapath signals

  logic [`DATA_W-1:0] opr;
  logic [`DATA_W-1:0] a_byp_data;
  logic a_byp;
  logic accept;
  logic commit;
  logic stall;
  logic to_file;
  logic is_sub;
  logic [`DATA_W-1:0] minuend;
  logic [`DATA_W:0] diff;
  logic nib_ok;
  logic [`DATA_W-1:0] res_rl;
  logic [`DATA_W-1:0] res_rr;
  logic [`DATA_W-1:0] res;
  logic mem_we;
  logic [`FADDR_W-1:0] mem_waddr;
  logic [`DATA_W-1:0] mem_wdata;
  logic bus_mem_wr;
  logic opr_msb;
  logic opr_lsb;
  logic [`DATA_W-2:0] opr_low7;
  logic [`DATA_W-2:0] opr_hi7;
  logic [`NIB_W-1:0] acc_lo;
  logic [`NIB_W-1:0] minuend_lo;
  rsx_pkg::status_t ws;
  logic [`DATA_W-1:0] ctrl_rd;

  assign accept = inst_valid_in && q.ready;
  assign bus_mem_wr = bus_in.wr && !bus_in.addr[`BUS_AW-1];
  // literal subtract has no file operand, whatever its dest bit says
  assign to_file = (q.inst.op != rsx_pkg::sub_from_literal_op) &&
                   (q.inst.dest == `DEST_FILE);
  // one write port: a bus write to the file holds a file-bound result
  assign stall = (q.fsm == rsx_pkg::st_exec) && to_file && bus_mem_wr;
  assign commit = (q.fsm == rsx_pkg::st_exec) && !stall;

  assign is_sub = (q.inst.op == rsx_pkg::sub_from_literal_op) ||
                  (q.inst.op == rsx_pkg::sub_acc_from_file_op);
  assign minuend = (q.inst.op == rsx_pkg::sub_from_literal_op) ?
                   q.inst.lit : opr;
  // borrow out of bit 8 means the accumulator was larger
  assign diff = {1'b0, minuend} - {1'b0, q.acc};
  assign acc_lo = q.acc[`NIB_W-1:0];
  assign minuend_lo = minuend[`NIB_W-1:0];
  assign nib_ok = acc_lo <= minuend_lo;
  assign res_rl = {opr[`DATA_W-2:0], q.st.carry_bit};
  assign res_rr = {q.st.carry_bit, opr[`DATA_W-1:1]};

  assign opr_msb = opr[`DATA_W-1];
  assign opr_lsb = opr[0];
  assign opr_low7 = opr[`DATA_W-2:0];
  assign opr_hi7 = opr[`DATA_W-1:1];
  assign ws = rsx_pkg::status_t'(bus_in.wdata[`STATUS_W-1:0]);

  always_comb begin
    ctrl_rd = `ZERO_BYTE;
    ctrl_rd[`CTRL_SLEEP_POS] = q.fsm == rsx_pkg::st_sleep;
    ctrl_rd[`CTRL_ILLEGAL_POS] = q.illegal;
  end

  ////////////////////////////////////////////////////////////////////
  // register read path: file words from the array, rest bypassed

  always_comb begin
    a_byp = 1'b1;
    a_byp_data = `ZERO_BYTE;
    if (bus_in.rd) begin
      if (!bus_in.addr[`BUS_AW-1]) begin
        a_byp = 1'b0;
      end else if (bus_in.addr == `ADDR_ACC) begin
        a_byp_data = q.acc;
      end else if (bus_in.addr == `ADDR_STATUS) begin
        a_byp_data = {{(`DATA_W-`STATUS_W){1'b0}}, q.st};
      end else if (bus_in.addr == `ADDR_CTRL) begin
        a_byp_data = ctrl_rd;
      end
    end
  end

  file_mem u_file (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .we_in(mem_we),
    .waddr_in(mem_waddr),
    .wdata_in(mem_wdata),
    .a_addr_in(bus_in.addr[`FADDR_W-1:0]),
    .a_byp_in(a_byp),
    .a_byp_data_in(a_byp_data),
    .b_en_in(accept),
    .b_addr_in(inst_in.faddr),
    .a_data_out(rd_data_out),
    .b_data_out(opr)
  );

  ////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d = q;
    d.wdt_clr = 1'b0;
    res = `ZERO_BYTE;
    mem_we = bus_mem_wr;
    mem_waddr = bus_in.addr[`FADDR_W-1:0];
    mem_wdata = bus_in.wdata;
    // bus writes first; instruction effects below win on collision
    if (bus_in.wr) begin
      if (bus_in.addr == `ADDR_ACC) begin
        d.acc = bus_in.wdata;
      end else if (bus_in.addr == `ADDR_STATUS) begin
        // timeout and power-down are read-only to software
        d.st.zero_bit = ws.zero_bit;
        d.st.nibble_borrow_bit = ws.nibble_borrow_bit;
        d.st.carry_bit = ws.carry_bit;
      end else if (bus_in.addr == `ADDR_CTRL) begin
        if (bus_in.wdata[`CTRL_ILLEGAL_POS]) begin
          d.illegal = 1'b0;
        end
      end
    end
    case (q.fsm)
      rsx_pkg::st_idle: begin
        if (accept) begin
          d.inst = inst_in;
          if (inst_in.op == rsx_pkg::sleep_op) begin
            d.fsm = rsx_pkg::st_sleep;
            d.st.powerdown_bit = 1'b0;
            d.st.timeout_bit = 1'b1;
            d.wdt_clr = 1'b1;
            d.osc_stop = 1'b1;
          end else if (!(inst_in.op inside {rsx_pkg::rotate_left_op, rsx_pkg::rotate_right_op,
                         rsx_pkg::sub_from_literal_op, rsx_pkg::sub_acc_from_file_op})) begin
            // unknown code: dropped, flagged; set beats a same-cycle clear
            d.illegal = 1'b1;
          end else begin
            d.fsm = rsx_pkg::st_exec;
          end
        end
      end
      rsx_pkg::st_exec: begin
        if (!stall) begin
          case (q.inst.op)
            rsx_pkg::rotate_left_op: begin
              res = res_rl;
              d.st.carry_bit = opr_msb;
            end
            rsx_pkg::rotate_right_op: begin
              res = res_rr;
              d.st.carry_bit = opr_lsb;
            end
            default: begin
              res = diff[`DATA_W-1:0];
            end
          endcase
          if (is_sub) begin
            d.st.carry_bit = !diff[`DATA_W];
            d.st.nibble_borrow_bit = nib_ok;
            d.st.zero_bit = res == `ZERO_BYTE;
          end
          if (to_file) begin
            mem_we = 1'b1;
            mem_waddr = q.inst.faddr;
            mem_wdata = res;
          end else begin
            d.acc = res;
          end
          d.fsm = rsx_pkg::st_idle;
        end
      end
      rsx_pkg::st_sleep: begin
        // oscillator stays stopped until woken by pin or software
        if (wake_in || (bus_in.wr && bus_in.addr == `ADDR_CTRL &&
                        bus_in.wdata[`CTRL_WAKE_POS])) begin
          d.fsm = rsx_pkg::st_idle;
          d.osc_stop = 1'b0;
        end
      end
      default: begin
        d.fsm = rsx_pkg::st_idle;
      end
    endcase
    d.ready = d.fsm == rsx_pkg::st_idle;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end

  assign inst_ready_out = q.ready;
  assign osc_stop_out = q.osc_stop;
  assign wdt_clear_out = q.wdt_clr;
  assign acc_out = q.acc;
  assign status_out = q.st;

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  dest_acc_a: assert property (
    commit && !to_file
    |=> acc_out == $past(res) && $past(!mem_we || bus_mem_wr)
  ) else $error("result not routed to accumulator");

  dest_file_a: assert property (
    commit && to_file && !bus_in.wr
    |-> mem_we && mem_wdata == res ##1 acc_out == $past(acc_out)
  ) else $error("result not routed to file register");

  file_addr_a: assert property (
    commit && to_file |-> mem_waddr == q.inst.faddr
  ) else $error("file write at wrong address");

  rotl_flags_a: assert property (
    commit && q.inst.op == rsx_pkg::rotate_left_op && !bus_in.wr
    |=> status_out.carry_bit == $past(opr_msb) &&
        status_out.zero_bit == $past(status_out.zero_bit) &&
        status_out.nibble_borrow_bit == $past(status_out.nibble_borrow_bit)
  ) else $error("rotate left changed a flag other than carry");

  rotl_bits_a: assert property (
    commit && q.inst.op == rsx_pkg::rotate_left_op && !to_file
    |=> acc_out == {$past(opr_low7), $past(status_out.carry_bit)}
  ) else $error("rotate left bits wrong");

  rotr_bits_a: assert property (
    commit && q.inst.op == rsx_pkg::rotate_right_op && !to_file
    |=> acc_out == {$past(status_out.carry_bit), $past(opr_hi7)} &&
        status_out.carry_bit == $past(opr_lsb)
  ) else $error("rotate right bits wrong");

  sleep_flags_a: assert property (
    accept && inst_in.op == rsx_pkg::sleep_op
    |=> !status_out.powerdown_bit && status_out.timeout_bit
  ) else $error("sleep status bits wrong");

  sleep_wdt_a: assert property (
    accept && inst_in.op == rsx_pkg::sleep_op
    |=> wdt_clear_out ##1 !wdt_clear_out
  ) else $error("watchdog clear not a single pulse");

  sleep_osc_a: assert property (
    accept && inst_in.op == rsx_pkg::sleep_op
    |=> osc_stop_out && !inst_ready_out
  ) else $error("oscillator not stopped in sleep");

  osc_held_a: assert property (
    q.fsm == rsx_pkg::st_sleep && !wake_in &&
    !(bus_in.wr && bus_in.addr == `ADDR_CTRL && bus_in.wdata[`CTRL_WAKE_POS])
    |=> osc_stop_out && !inst_ready_out
  ) else $error("oscillator restarted without a wake");

  illegal_drop_a: assert property (
    accept && !bus_in.wr && !(inst_in.op inside {rsx_pkg::rotate_left_op,
      rsx_pkg::rotate_right_op, rsx_pkg::sub_from_literal_op,
      rsx_pkg::sub_acc_from_file_op, rsx_pkg::sleep_op})
    |=> inst_ready_out && q.illegal && acc_out == $past(acc_out)
  ) else $error("unknown code not dropped");

  sublit_res_a: assert property (
    commit && q.inst.op == rsx_pkg::sub_from_literal_op
    |=> acc_out == 8'($past(q.inst.lit) - $past(q.acc)) &&
        status_out.zero_bit == (acc_out == `ZERO_BYTE)
  ) else $error("literal subtract result wrong");

  sublit_flags_a: assert property (
    commit && q.inst.op == rsx_pkg::sub_from_literal_op
    |=> status_out.carry_bit == ($past(q.acc) <= $past(q.inst.lit)) &&
        status_out.nibble_borrow_bit == ($past(acc_lo) <= $past(minuend_lo))
  ) else $error("literal subtract flags wrong");

  subf_res_a: assert property (
    commit && q.inst.op == rsx_pkg::sub_acc_from_file_op && to_file
    |-> mem_wdata == 8'(opr - q.acc)
  ) else $error("file subtract result wrong");

  subf_flags_a: assert property (
    commit && q.inst.op == rsx_pkg::sub_acc_from_file_op
    |=> status_out.carry_bit == ($past(q.acc) <= $past(opr)) &&
        status_out.nibble_borrow_bit == ($past(acc_lo) <= $past(minuend_lo))
  ) else $error("file subtract flags wrong");

endmodule

//--- tb/decoder_model.sv
/*
  instruction source standing in for the core decoder: offers one word
  when started and holds it until the block takes it.
  assumes the valid/ready handshake on one rising-edge clock.
*/
`timescale 1ns/1ns

module decoder_model (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic start_in,
  input wire rsx_pkg::inst_t next_in,
  input wire logic ready_in,
  output logic valid_out,
  output rsx_pkg::inst_t inst_out
);
  // once taken the lines show the inverse, so a stale word is never reused by luck
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      valid_out <= 1'b0;
      inst_out <= '0;
    end else if (valid_out && ready_in) begin
      valid_out <= 1'b0;
      inst_out <= rsx_pkg::inst_t'(~inst_out);
    end else if (start_in && !valid_out) begin
      valid_out <= 1'b1;
      inst_out <= next_in;
    end
  end
endmodule

//--- tb/tb_rotate_subtract_sleep_exec.sv
/*
  self-checking bench of the rotate / subtract / sleep block.
  assumes the decoder model beside it and the plain register port.
*/
`timescale 1ns/1ns
`include "rsx_consts.svh"

`define CHK(what, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("wrong value %s expected %h seen %h", what, exp, got); \
    end \
  end

module tb_rotate_subtract_sleep_exec;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic start = 1'b0;
  logic wake = 1'b0;
  rsx_pkg::bus_req_t bus = '0;
  rsx_pkg::inst_t next_inst = '0;
  rsx_pkg::inst_t inst;
  rsx_pkg::status_t status;
  logic inst_valid;
  logic inst_ready;
  logic osc_stop;
  logic wdt_clear;
  logic [7:0] acc;
  logic [7:0] rd_data;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;

  rotate_subtract_sleep_exec uut (
    .clk_in(clk), .srst_in(srst), .bus_in(bus), .rd_data_out(rd_data),
    .inst_valid_in(inst_valid), .inst_in(inst), .inst_ready_out(inst_ready),
    .wake_in(wake), .osc_stop_out(osc_stop), .wdt_clear_out(wdt_clear),
    .acc_out(acc), .status_out(status)
  );

  decoder_model decoder (
    .clk_in(clk), .srst_in(srst), .start_in(start), .next_in(next_inst),
    .ready_in(inst_ready), .valid_out(inst_valid), .inst_out(inst)
  );

  initial begin
    forever #5 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////
  task give_verdict;
    if (n_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      give_verdict();
    end
  end

  task bw(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
  endtask

  // read data stand only in the cycle after the strobe
  task br(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus <= '0;
    @(negedge clk);
    `CHK(what, exp, rd_data);
  endtask

  // returns in the cycle after the word is taken
  task issue(input rsx_pkg::op_t o, input logic [6:0] f, input logic d, input logic [7:0] l);
    int n;
    @(posedge clk);
    start <= 1'b1;
    next_inst <= '{op: o, faddr: f, dest: d, lit: l};
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (inst_valid !== 1'b0 && n < 20);
    if (n == 20) n_errors++;
  endtask

  task exec(input rsx_pkg::op_t o, input logic [6:0] f, input logic d, input logic [7:0] l);
    int n;
    issue(o, f, d, l);
    n = 0;
    while (inst_ready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (n == 20) n_errors++;
  endtask

  // {result, zero, nibble no-borrow, no-borrow} of a - w
  function automatic logic [10:0] sub_exp(input logic [7:0] a, input logic [7:0] w);
    logic [7:0] r;
    r = a - w;
    sub_exp = {r, r == 8'h00, w[3:0] <= a[3:0], w <= a};
  endfunction

  //////////////////////////////////////////////////////////////////////////
  task t_reset;
    `CHK("acc", 8'h00, acc);
    `CHK("status", 5'h18, status);
    `CHK("osc stop", 1'b0, osc_stop);
    `CHK("ready", 1'b1, inst_ready);
    br(`ADDR_STATUS, 8'h18, "status read");
    br(8'h83, 8'h00, "unmapped read");
  endtask

  task t_rotate;
    bw(8'h7F, 8'hE6);
    bw(`ADDR_STATUS, 8'h06);
    exec(rsx_pkg::rotate_left_op, 7'h7F, 1'b0, 8'h00);
    `CHK("rl acc", 8'hCC, acc);
    `CHK("rl status", 5'h1F, status);
    br(8'h7F, 8'hE6, "rl file kept");
    exec(rsx_pkg::rotate_right_op, 7'h7F, 1'b1, 8'h00);
    `CHK("rr acc", 8'hCC, acc);
    `CHK("rr status", 5'h1E, status);
    br(8'h7F, 8'hF3, "rr file");
    exec(rsx_pkg::rotate_left_op, 7'h7F, 1'b1, 8'h00);
    `CHK("rl carry", 5'h1F, status);
    br(8'h7F, 8'hE6, "rl file");
  endtask

  task t_sublit;
    logic [7:0] lits [4] = '{8'h10, 8'h10, 8'h10, 8'h00};
    logic [7:0] accs [4] = '{8'h01, 8'h20, 8'h10, 8'hFF};
    logic [10:0] e;
    for (int i = 0; i < 4; i++) begin
      bw(`ADDR_ACC, accs[i]);
      bw(`ADDR_STATUS, 8'h00);
      e = sub_exp(lits[i], accs[i]);
      exec(rsx_pkg::sub_from_literal_op, 7'h00, i[0], lits[i]);
      `CHK("sublit acc", e[10:3], acc);
      `CHK("sublit status", {2'b11, e[2:0]}, status);
    end
  endtask

  task t_subfile;
    logic [7:0] fv [2] = '{8'h33, 8'h40};
    logic [7:0] av [2] = '{8'h34, 8'h40};
    logic [10:0] e;
    for (int i = 0; i < 2; i++) begin
      bw(8'h05, fv[i]);
      bw(`ADDR_ACC, av[i]);
      e = sub_exp(fv[i], av[i]);
      exec(rsx_pkg::sub_acc_from_file_op, 7'h05, ~i[0], 8'h00);
      `CHK("subf status", {2'b11, e[2:0]}, status);
      if (i == 0) begin
        `CHK("subf acc kept", av[i], acc);
        br(8'h05, e[10:3], "subf file");
      end else begin
        `CHK("subf acc", e[10:3], acc);
        br(8'h05, fv[i], "subf file kept");
      end
    end
  endtask

  // a bus write to the file in the execute cycle holds a file-bound result back
  task t_stall;
    bw(8'h10, 8'h81);
    bw(`ADDR_STATUS, 8'h00);
    @(posedge clk);
    start <= 1'b1;
    next_inst <= '{op: rsx_pkg::rotate_left_op, faddr: 7'h10, dest: 1'b1, lit: 8'h00};
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: 8'h11, wdata: 8'h5A};
    @(posedge clk);
    bus <= '0;
    @(negedge clk);
    `CHK("stall ready", 1'b0, inst_ready);
    @(negedge clk);
    `CHK("stall ready back", 1'b1, inst_ready);
    `CHK("stall status", 5'h19, status);
    br(8'h10, 8'h02, "stall file");
    br(8'h11, 8'h5A, "stall bus write");
  endtask

  // every code outside the decoded set is dropped and flagged
  task t_illegal;
    logic [2:0] codes [3] = '{3'h0, 3'h6, 3'h7};
    for (int i = 0; i < 3; i++) begin
      exec(rsx_pkg::op_t'(codes[i]), 7'h00, 1'b0, 8'h00);
      `CHK("illegal ready", 1'b1, inst_ready);
      `CHK("illegal acc kept", 8'h00, acc);
      br(`ADDR_CTRL, 8'h04, "illegal flag");
      bw(`ADDR_CTRL, 8'h04);
      br(`ADDR_CTRL, 8'h00, "illegal cleared");
    end
  endtask

  task t_sleep;
    for (int i = 0; i < 2; i++) begin
      issue(rsx_pkg::sleep_op, 7'h00, 1'b0, 8'h00);
      `CHK("osc stop", 1'b1, osc_stop);
      `CHK("wdt clear", 1'b1, wdt_clear);
      `CHK("to pd", 2'b10, status[4:3]);
      `CHK("ready asleep", 1'b0, inst_ready);
      @(negedge clk);
      `CHK("wdt pulse", 1'b0, wdt_clear);
      repeat (5) @(negedge clk);
      `CHK("osc held", 1'b1, osc_stop);
      br(`ADDR_CTRL, 8'h01, "sleep flag");
      if (i == 0) begin
        @(posedge clk);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
      end else begin
        bw(`ADDR_CTRL, 8'h02);
      end
      @(negedge clk);
      `CHK("osc woken", 1'b0, osc_stop);
      `CHK("ready woken", 1'b1, inst_ready);
    end
  endtask

  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    t_reset();
    t_rotate();
    t_sublit();
    t_subfile();
    t_stall();
    t_illegal();
    t_sleep();
    give_verdict();
  end
endmodule
